//--- logic/oscc_pkg.sv
// Constants for the on/off switch cycle controller core.
// Assumes a 40 MHz system clock; all analog sensing arrives as comparator levels.
package oscc_pkg;
	// ****************************************
	// Clock and oscillator
	// ****************************************
	localparam int CLK_HZ = 40_000_000;
	localparam int OSC_HZ = 132_000;
	localparam int DITHER_PP_HZ = 8_000;
	localparam int DITHER_RATE_HZ = 1_000;
	localparam int PERIOD_MIN = CLK_HZ / (OSC_HZ + DITHER_PP_HZ / 2);
	localparam int PERIOD_MAX = CLK_HZ / (OSC_HZ - DITHER_PP_HZ / 2);
	localparam int DITHER_SPAN = PERIOD_MAX - PERIOD_MIN;
	localparam int DITHER_STEP = CLK_HZ / (DITHER_RATE_HZ * 2 * DITHER_SPAN);
	localparam int MAX_DUTY_PCT = 65;
	localparam int DUTY_CYC = (CLK_HZ / OSC_HZ) * MAX_DUTY_PCT / 100;
	localparam int PERIOD_W = 10;
	localparam int DSTEP_W = 11;
	localparam int DOFF_W = 5;

	// ****************************************
	// Pulse timing
	// ****************************************
	localparam int BLANK_NS = 200;
	localparam int BLANK_CYC = (BLANK_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int MIN_ON_NS = 400;
	localparam int MIN_ON_CYC = (MIN_ON_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam int TIMER_W = 8;

	// ****************************************
	// Auto-restart, counted in oscillator cycles
	// ****************************************
	localparam int FAULT_MS = 64;
	localparam int OFF_MS = 2500;
	localparam int FAULT_OSC = FAULT_MS * OSC_HZ / 1000;
	localparam int OFF_OSC = OFF_MS * (OSC_HZ / 1000);
	localparam int AR_W = 20;

	// ****************************************
	// Current limit state machine
	// ****************************************
	localparam int RUN_UP = 2;
	localparam int SKIP_DOWN = 4;
	localparam int SEQ_W = 4;
	localparam logic [1:0] LEVEL_MAX = 2'h3;
	localparam logic [1:0] CAP_STD = 2'h0;
	localparam logic [1:0] CAP_LOW = 2'h1;
	localparam logic [1:0] CAP_HIGH = 2'h2;

	// Pin input bit positions in the synchroniser bus
	localparam int IN_EN = 0;
	localparam int IN_ILIM = 1;
	localparam int IN_LINE_OK = 2;
	localparam int IN_NO_RES = 3;
	localparam int IN_BP_LOW = 4;
	localparam int IN_BP_REG = 5;
	localparam int IN_HOT = 6;
	localparam int IN_COOLED = 7;
	localparam int IN_BP_SHUT = 8;
	localparam int IN_CAP0 = 9;
	localparam int IN_W = 11;

	typedef enum logic [0:0] {
		AR_RUN = 1'b0,
		AR_OFF = 1'b1
	} oscc_ar_e;
endpackage : oscc_pkg

//--- logic/oscc_sync3.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes every bit is an asynchronous level from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module oscc_sync3 #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic [WIDTH-1:0] pin_i,
	output logic [WIDTH-1:0] level_o
);
	logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
	logic [WIDTH-1:0] lvl_d;

	// Stage one feeds only stage two; a bit moves once stages two and three agree
	always_comb begin
		lvl_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & lvl_q);
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			lvl_q <= '0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign level_o = lvl_q;
endmodule : oscc_sync3
`default_nettype wire

//--- logic/oscc_core.sv
// Digital core of an on/off switch cycle controller.
// Assumes comparator levels from the analog front end on asynchronous pins.
// Notes on behaviour
// - Free-running oscillator gives cycle start, duty limit
// - Jitter range about 8 kHz, swept at 1 kHz
// - Enable sampled at cycle start decides conduction
// - Enable low while pin current above threshold
// - Enable changes after sampling are ignored
// - Limit level steps down light, up heavy
// - Current limit ends conduction for the cycle
// - Limit comparator blanked after each turn-on
// - Supply lockout below 4.9 V until 5.85 V
// - Regulator charges only while switch is off
// - Thermal shutdown at 142 C, 75 C hysteresis
// - Enable low clears the auto-restart counter
// - No enable low 64 ms, off 2.5 s
// - Line undervoltage halts the off-time counter
// - Extension holds switch past duty end until limit
// - Extension off until first enable low
// - Start-up and restart need line current ok
// - Hold rail low during start-up line undervoltage
// - Tiny line current means no resistor, ignore
// - Supply capacitor size sets the limit select output
// - Supply shutdown latch, released below 4.9 V
// - Short on-time lowers frequency at start-up/overload
`timescale 1ns/1ps
`default_nettype none
module oscc_core
	import oscc_pkg::*;
#(
	parameter int FAULT_CYC = FAULT_OSC,
	parameter int OFF_CYC = OFF_OSC
) (
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic enable_line_sense_input_i,
	input wire logic cur_limit_trip_i,
	input wire logic line_current_ok_i,
	input wire logic line_no_resistor_i,
	input wire logic supply_below_low_i,
	input wire logic supply_at_reg_i,
	input wire logic die_hot_i,
	input wire logic die_cooled_i,
	input wire logic supply_shutdown_i,
	input wire logic [1:0] supply_cap_size_i,
	output logic power_switch_o,
	output logic max_duty_signal_o,
	output logic cycle_start_o,
	output logic [1:0] cur_limit_level_o,
	output logic [1:0] cur_limit_select_o,
	output logic regulator_charge_o,
	output logic rail_hold_low_o,
	output logic restart_off_o,
	output logic extension_active_o
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [IN_W-1:0] pins, lvl;
	assign pins = {supply_cap_size_i, supply_shutdown_i, die_cooled_i, die_hot_i,
		supply_at_reg_i, supply_below_low_i, line_no_resistor_i, line_current_ok_i,
		cur_limit_trip_i, enable_line_sense_input_i};

	oscc_sync3 #(.WIDTH(IN_W)) u_sync (
		.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i),
		.pin_i(pins),
		.level_o(lvl)
	);

	logic en_s, ilim_s, line_uv;
	assign en_s = lvl[IN_EN];
	assign ilim_s = lvl[IN_ILIM];
	assign line_uv = !lvl[IN_NO_RES] && !lvl[IN_LINE_OK];

	// ****************************************
	// Oscillator with jitter
	// ****************************************
	logic [PERIOD_W-1:0] cnt_q, cnt_d, period_q, period_d;
	logic [DSTEP_W-1:0] dstep_q, dstep_d;
	logic [DOFF_W-1:0] doff_q, doff_d;
	logic dir_q, dir_d, tick, cs_q, cs_d, dmax_q, dmax_d, slow_q;

	always_comb begin
		tick = (cnt_q == period_q - PERIOD_W'(1));
		cnt_d = tick ? '0 : cnt_q + PERIOD_W'(1);
		cs_d = tick;
		dmax_d = (cnt_d < PERIOD_W'(DUTY_CYC));
		dstep_d = dstep_q + DSTEP_W'(1);
		doff_d = doff_q;
		dir_d = dir_q;
		if (dstep_q == DSTEP_W'(DITHER_STEP - 1)) begin
			dstep_d = '0;
			doff_d = dir_q ? doff_q + DOFF_W'(1) : doff_q - DOFF_W'(1);
			if (dir_q && doff_q == DOFF_W'(DITHER_SPAN - 1)) begin
				dir_d = 1'b0;
			end else if (!dir_q && doff_q == DOFF_W'(1)) begin
				dir_d = 1'b1;
			end
		end
		// Period only changes at a boundary so a cycle never tears
		period_d = period_q;
		if (tick) begin
			period_d = PERIOD_W'(PERIOD_MIN) + PERIOD_W'(doff_q);
			if (slow_q) begin
				period_d = period_d << 1;
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			cnt_q <= '0;
			period_q <= PERIOD_W'(PERIOD_MIN);
			dstep_q <= '0;
			doff_q <= '0;
			dir_q <= 1'b1;
			cs_q <= 1'b0;
			dmax_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			period_q <= period_d;
			dstep_q <= dstep_d;
			doff_q <= doff_d;
			dir_q <= dir_d;
			cs_q <= cs_d;
			dmax_q <= dmax_d;
		end
	end

	// ****************************************
	// Protection latches
	// ****************************************
	logic uvlo_q, uvlo_d, hot_q, hot_d, shut_q, shut_d, pwrup_q, pwrup_d;
	logic cap_taken_q, cap_taken_d;
	logic [1:0] cap_q, cap_d;

	always_comb begin
		uvlo_d = uvlo_q;
		if (lvl[IN_BP_LOW]) begin
			uvlo_d = 1'b1;
		end else if (lvl[IN_BP_REG]) begin
			uvlo_d = 1'b0;
		end
		hot_d = hot_q;
		if (lvl[IN_HOT]) begin
			hot_d = 1'b1;
		end else if (lvl[IN_COOLED]) begin
			hot_d = 1'b0;
		end
		shut_d = shut_q;
		if (lvl[IN_BP_SHUT]) begin
			shut_d = 1'b1;
		end else if (lvl[IN_BP_LOW]) begin
			shut_d = 1'b0;
		end
		pwrup_d = pwrup_q && !cs_d;
		if (pwrup_q && tick && !line_uv) begin
			pwrup_d = 1'b0;
		end
		// Strap read at first cycle start, after the synchroniser settled
		cap_taken_d = cap_taken_q || tick;
		cap_d = cap_q;
		if (tick && !cap_taken_q) begin
			case (lvl[IN_CAP0+1:IN_CAP0])
				CAP_LOW: cap_d = CAP_LOW;
				CAP_HIGH: cap_d = CAP_HIGH;
				default: cap_d = CAP_STD;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			uvlo_q <= 1'b1;
			hot_q <= 1'b0;
			shut_q <= 1'b0;
			pwrup_q <= 1'b1;
			cap_taken_q <= 1'b0;
			cap_q <= CAP_STD;
		end else begin
			uvlo_q <= uvlo_d;
			hot_q <= hot_d;
			shut_q <= shut_d;
			pwrup_q <= pwrup_d | (pwrup_q & line_uv);
			cap_taken_q <= cap_taken_d;
			cap_q <= cap_d;
		end
	end

	// ****************************************
	// Auto-restart and limit level sequencing
	// ****************************************
	oscc_ar_e ar_q, ar_d;
	logic [AR_W-1:0] ar_cnt_q, ar_cnt_d;
	logic [SEQ_W-1:0] run_q, run_d, skip_q, skip_d;
	logic [1:0] lvl_q, lvl_d;
	logic ext_q, ext_d;

	always_comb begin
		ar_d = ar_q;
		ar_cnt_d = ar_cnt_q;
		run_d = run_q;
		skip_d = skip_q;
		lvl_d = lvl_q;
		ext_d = ext_q;
		if (tick) begin
			case (ar_q)
				AR_RUN: begin
					if (!en_s) begin
						ar_cnt_d = '0;
					end else if (ar_cnt_q == AR_W'(FAULT_CYC - 1)) begin
						ar_cnt_d = '0;
						ar_d = AR_OFF;
					end else begin
						ar_cnt_d = ar_cnt_q + AR_W'(1);
					end
				end
				AR_OFF: begin
					if (line_uv) begin
						ar_cnt_d = ar_cnt_q;
					end else if (ar_cnt_q >= AR_W'(OFF_CYC - 1)) begin
						ar_cnt_d = '0;
						ar_d = AR_RUN;
					end else begin
						ar_cnt_d = ar_cnt_q + AR_W'(1);
					end
				end
				default: ar_d = AR_RUN;
			endcase
			if (en_s) begin
				skip_d = '0;
				run_d = run_q + SEQ_W'(1);
				if (run_q == SEQ_W'(RUN_UP - 1)) begin
					run_d = '0;
					if (lvl_q != LEVEL_MAX) begin
						lvl_d = lvl_q + 2'h1;
					end
				end
			end else begin
				run_d = '0;
				ext_d = 1'b1;
				skip_d = skip_q + SEQ_W'(1);
				if (skip_q == SEQ_W'(SKIP_DOWN - 1)) begin
					skip_d = '0;
					if (lvl_q != 2'h0) begin
						lvl_d = lvl_q - 2'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			ar_q <= AR_RUN;
			ar_cnt_q <= '0;
			run_q <= '0;
			skip_q <= '0;
			lvl_q <= LEVEL_MAX;
			ext_q <= 1'b0;
		end else begin
			ar_q <= ar_d;
			ar_cnt_q <= ar_cnt_d;
			run_q <= run_d;
			skip_q <= skip_d;
			lvl_q <= lvl_d;
			ext_q <= ext_d;
		end
	end

	// ****************************************
	// Switch drive
	// ****************************************
	logic sw_q, sw_d, block, slow_d, hold_d, hold_q;
	logic [TIMER_W-1:0] blank_q, blank_d, on_q, on_d;

	always_comb begin
		// Start-up and restart still need line current before the first turn-on
		block = uvlo_q || hot_q || shut_q || (ar_q == AR_OFF)
			|| ((pwrup_q || ar_q == AR_OFF) && line_uv);
		sw_d = sw_q;
		blank_d = (blank_q != '0) ? blank_q - TIMER_W'(1) : blank_q;
		on_d = (sw_q && on_q != '1) ? on_q + TIMER_W'(1) : on_q;
		slow_d = slow_q;
		if (tick) begin
			sw_d = en_s && !block;
			blank_d = TIMER_W'(BLANK_CYC);
			on_d = '0;
		end else if (sw_q) begin
			if (blank_q == '0 && ilim_s) begin
				sw_d = 1'b0;
			end else if (!dmax_q && !ext_q) begin
				sw_d = 1'b0;
			end
		end
		if (sw_q && !sw_d) begin
			// Short pulses at start-up or overload mean the loop has lost control
			slow_d = (on_q < TIMER_W'(MIN_ON_CYC)) && (!ext_q || ar_cnt_q != '0);
		end
		hold_d = pwrup_q && line_uv;
	end

	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			sw_q <= 1'b0;
			blank_q <= '0;
			on_q <= '0;
			slow_q <= 1'b0;
			hold_q <= 1'b0;
		end else begin
			sw_q <= sw_d;
			blank_q <= blank_d;
			on_q <= on_d;
			slow_q <= slow_d;
			hold_q <= hold_d;
		end
	end

	logic chg_q, ar_off_q;
	always_ff @(posedge sys_clk_i) begin
		if (!reset_n_i) begin
			chg_q <= 1'b1;
			ar_off_q <= 1'b0;
		end else begin
			chg_q <= !sw_d;
			ar_off_q <= (ar_d == AR_OFF);
		end
	end

	assign power_switch_o = sw_q;
	assign max_duty_signal_o = dmax_q;
	assign cycle_start_o = cs_q;
	assign cur_limit_level_o = lvl_q;
	assign cur_limit_select_o = cap_q;
	assign regulator_charge_o = chg_q;
	assign rail_hold_low_o = hold_q;
	assign restart_off_o = ar_off_q;
	assign extension_active_o = ext_q;

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!reset_n_i);

	a_start_pulse_single: assert property (cs_q |=> !cs_q)
		else $error("cycle start longer than one clock");
	a_jitter_period_range: assert property (period_q >= PERIOD_W'(PERIOD_MIN))
		else $error("period below jitter range");
	a_turn_on_at_start: assert property ($rose(sw_q) |-> cs_q && $past(en_s))
		else $error("switch turned on away from a sampled enable");
	a_blank_min_on: assert property ($rose(sw_q) |-> sw_q [*8])
		else $error("pulse ended inside blanking");
	a_limit_ends_pulse: assert property (sw_q && blank_q == '0 && ilim_s && !tick |=> !sw_q)
		else $error("current limit did not end the pulse");
	a_duty_end_off: assert property (sw_q && !dmax_q && !ext_q && !tick |=> !sw_q)
		else $error("pulse outlived duty limit without extension");
	a_block_turn_on: assert property ($rose(sw_q) |-> !$past(block))
		else $error("switch turned on while disabled");
	a_charge_when_off: assert property (regulator_charge_o == !sw_q)
		else $error("regulator charging while switch on");
	a_latch_holds: assert property (shut_q && !lvl[IN_BP_LOW] |=> shut_q)
		else $error("shutdown latch released without supply drop");
endmodule : oscc_core
`default_nettype wire

//--- dv/oscc_far_side.sv
// Far-side model: feedback optocoupler and switch current sense.
// Assumes the bench sets load demand and the current ramp length in clocks.
`timescale 1ns/1ps
`default_nettype none
module oscc_far_side (
	input wire logic sys_clk_i,
	input wire logic power_switch_i,
	input wire logic demand_i,
	input wire logic [8:0] ramp_i,
	output logic enable_o,
	output logic trip_o
);
	// ****************************************
	// Current ramp
	// ****************************************
	int on_cnt = 0;
	logic [8:0] ramp_q = 9'h000;
	// Opto pulls the line low once the output is above regulation
	assign enable_o = demand_i;
	// Ramp length latched while off, so a mid-pulse change cannot cut the pulse
	always @(posedge sys_clk_i) begin
		if (power_switch_i) begin
			on_cnt <= on_cnt + 1;
		end else begin
			on_cnt <= 0;
			ramp_q <= ramp_i;
		end
	end
	// Current collapses as soon as the switch opens
	assign trip_o = power_switch_i && (on_cnt >= int'(ramp_q));
endmodule : oscc_far_side
`default_nettype wire

//--- dv/tb_top.sv
// Bench for the switch cycle controller core with a cycle-level model.
// Assumes short auto-restart windows set through the core parameters.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import oscc_pkg::*;
	logic sys_clk_i = 0, reset_n_i = 0, demand = 1, line_ok = 1, hot = 0, cooled = 0;
	logic below = 0, at_reg = 0, shut = 0, en_pin, ilim, sw, mduty, cst, chg, roff, ext;
	logic [1:0] strap = 2'h0, lvl, sel;
	logic nores = 0, hold;
	logic [8:0] ramp = 9'h03c;
	int err_count = 0, tests_run = 0, clks = 0, n, r, on_t, duty_t, per_t, last_per;
	int ons = 0, r_on, lvl_m, run_m, skip_m, lo, hi;
	integer seed = 76049;
	bit chk = 1, chk_lvl = 0, chk_per = 0, blk = 1, ext_m, started, sw_prev;

	oscc_core #(.FAULT_CYC(8), .OFF_CYC(10)) i_oscc_core (.sys_clk_i(sys_clk_i),
		.reset_n_i(reset_n_i), .enable_line_sense_input_i(en_pin), .cur_limit_trip_i(ilim),
		.line_current_ok_i(line_ok), .line_no_resistor_i(nores), .supply_below_low_i(below),
		.supply_at_reg_i(at_reg), .die_hot_i(hot), .die_cooled_i(cooled),
		.supply_shutdown_i(shut), .supply_cap_size_i(strap), .power_switch_o(sw),
		.max_duty_signal_o(mduty), .cycle_start_o(cst), .cur_limit_level_o(lvl),
		.cur_limit_select_o(sel), .regulator_charge_o(chg), .rail_hold_low_o(hold),
		.restart_off_o(roff), .extension_active_o(ext));
	oscc_far_side i_oscc_far_side (.sys_clk_i(sys_clk_i), .power_switch_i(sw),
		.demand_i(demand), .ramp_i(ramp), .enable_o(en_pin), .trip_o(ilim));

	initial forever #12.5 sys_clk_i = ~sys_clk_i;

	// ****************************************
	// Compare and control tasks
	// ****************************************
	task automatic cmp_val(input logic [3:0] got, input logic [3:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : cmp_val
	task automatic cmp_range(input int got, input int l, input int h);
		tests_run++;
		if (got < l || got > h) begin
			err_count++;
			$display("unexpected at %0t: got %h exp %h..%h", $time, got, l, h);
		end
	endtask : cmp_range
	task automatic wait_start();
		int k;
		k = 0;
		do begin
			@(posedge sys_clk_i);
			k++;
		end while (cst !== 1'b1 && k < 700);
		if (k >= 700) cmp_val(4'h0, 4'h1);
	endtask : wait_start
	// Inputs move mid-cycle so they are settled well before the next sample
	task automatic cyc(input logic e, input logic [8:0] rl, input bit b);
		wait_start();
		repeat (20) @(posedge sys_clk_i);
		demand <= e;
		ramp <= rl;
		blk = b;
	endtask : cyc
	task automatic count_off(input logic v, output int c);
		c = 0;
		while (roff !== v && c < 60) begin
			wait_start();
			c++;
		end
	endtask : count_off
	task automatic do_reset();
		reset_n_i <= 1'b0;
		repeat (5) @(posedge sys_clk_i);
		reset_n_i <= 1'b1;
	endtask : do_reset
	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : wrap_up

	always @(posedge sys_clk_i) begin
		clks++;
		if (clks >= 80000) begin
			err_count++;
			wrap_up();
		end
	end

	// ****************************************
	// Cycle model, checked at every edge
	// ****************************************
	always @(posedge sys_clk_i) begin
		if (reset_n_i !== 1'b1) begin
			lvl_m = 3;
			run_m = 0;
			skip_m = 0;
			ext_m = 0;
			started = 0;
			on_t = 0;
		end else begin
			cmp_val(chg, !sw);
			if (sw === 1'b1) on_t++;
			if (mduty === 1'b1) duty_t++;
			per_t++;
			if (sw_prev && sw !== 1'b1) begin
				lo = (r_on > BLANK_CYC) ? r_on : BLANK_CYC;
				hi = lo + 8;
				if (!ext_m && lo > DUTY_CYC) begin
					lo = DUTY_CYC - 1;
					hi = DUTY_CYC + 2;
				end
				cmp_range(on_t, lo, hi);
				on_t = 0;
			end
			if (cst === 1'b1) begin
				if (started && chk_per) begin
					cmp_range(per_t, PERIOD_MIN, PERIOD_MAX);
					cmp_range(duty_t, DUTY_CYC - 1, DUTY_CYC + 1);
				end
				last_per = per_t;
				per_t = 0;
				duty_t = 0;
				started = 1;
				r_on = ramp;
				if (sw === 1'b1) ons++;
				if (chk) begin
					cmp_val(sw, demand && !blk);
					if (chk_lvl) begin
						// Level already holds this start's sample, so update first
						run_m = demand ? run_m + 1 : 0;
						skip_m = demand ? 0 : skip_m + 1;
						if (run_m == RUN_UP) begin
							run_m = 0;
							lvl_m = (lvl_m < 3) ? lvl_m + 1 : 3;
						end
						if (skip_m == SKIP_DOWN) begin
							skip_m = 0;
							lvl_m = (lvl_m > 0) ? lvl_m - 1 : 0;
						end
						cmp_val(lvl, 4'(lvl_m));
					end
					if (!demand) ext_m = 1;
				end
			end
		end
		sw_prev = (sw === 1'b1);
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial begin
		logic e;
		do_reset();
		cyc(1, 9'h03c, 1);
		cyc(1, 9'h03c, 0);
		at_reg <= 1'b1;
		cyc(1, 9'h03c, 0);
		$display("test lockout done");
		strap <= 2'({$random(seed)} % 3);
		chk_lvl = 1;
		ramp <= 9'h0fa;
		do_reset();
		repeat (3) cyc(1, 9'h0fa, 0);
		cmp_val(sel, strap);
		cmp_val(ext, 1'b0);
		chk_per = 1;
		for (int i = 0; i < 40; i++) begin
			e = (i % 4 == 3) ? 1'b0 : 1'($random(seed) & 1);
			cyc(e, 9'({$random(seed)} % 130 + 20), 0);
		end
		chk_per = 0;
		chk_lvl = 0;
		cmp_val(ext, 1'b1);
		$display("test random load done");
		cyc(1, 9'h0fa, 0);
		cyc(1, 9'h000, 0);
		cyc(1, 9'h03c, 0);
		cyc(0, 9'h03c, 0);
		cyc(0, 9'h03c, 0);
		cmp_range(last_per, 2 * PERIOD_MIN, 2 * PERIOD_MAX);
		$display("test extension and blanking done");
		cyc(1, 9'h03c, 1);
		hot <= 1'b1;
		cyc(0, 9'h03c, 1);
		cyc(1, 9'h03c, 1);
		hot <= 1'b0;
		cyc(1, 9'h03c, 0);
		cooled <= 1'b1;
		cyc(0, 9'h03c, 0);
		cooled <= 1'b0;
		cyc(1, 9'h03c, 1);
		shut <= 1'b1;
		cyc(0, 9'h03c, 1);
		shut <= 1'b0;
		cyc(1, 9'h03c, 1);
		below <= 1'b1;
		cyc(1, 9'h03c, 0);
		below <= 1'b0;
		cyc(0, 9'h03c, 0);
		wait_start();
		$display("test protections done");
		chk = 0;
		demand <= 1'b1;
		ramp <= 9'h028;
		do_reset();
		count_off(1, n);
		cmp_range(n, 7, 10);
		// One more edge so the last enabled pulse is already counted
		@(posedge sys_clk_i);
		r = ons;
		count_off(0, n);
		cmp_range(n, 9, 12);
		cmp_range(ons - r, 0, 0);
		count_off(1, n);
		line_ok <= 1'b0;
		repeat (20) wait_start();
		cmp_val(roff, 1'b1);
		line_ok <= 1'b1;
		count_off(0, n);
		cmp_range(n, 1, 12);
		repeat (4) wait_start();
		demand <= 1'b0;
		wait_start();
		demand <= 1'b1;
		count_off(1, n);
		cmp_range(n, 7, 10);
		$display("test auto-restart done");
		line_ok <= 1'b0;
		do_reset();
		repeat (20) @(posedge sys_clk_i);
		cmp_val(hold, 1'b1);
		nores <= 1'b1;
		repeat (10) @(posedge sys_clk_i);
		cmp_val(hold, 1'b0);
		$display("test line sense done");
		wrap_up();
	end
endmodule : tb_top
`default_nettype wire
